// ---- rtl/scg_regs.vh ----
`ifndef SCG_REGS_VH
`define SCG_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SCG_ADDR_W         4
`define SCG_OFS_CLKDIS     4'h0
`define SCG_OFS_PWRSTATE   4'h4
`define SCG_OFS_STATUS     4'h8

// ****************************************************************
// Field layouts and reset values
// ****************************************************************
`define SCG_NUM_OUT        5
`define SCG_CLKDIS_RST     5'h00
`define SCG_PSTATE_W       2
`define SCG_PSTATE_RST     2'h0
`define SCG_PSTATE_D0      2'h0
`define SCG_PSTATE_D1      2'h1
`define SCG_PSTATE_D2      2'h2
`define SCG_PSTATE_D3HOT   2'h3
`define SCG_STS_RUN_LSB    0
`define SCG_STS_B2_BIT     5
`define SCG_STS_STRAP_BIT  6
`define SCG_STS_PCLK_BIT   7

// ****************************************************************
// Timing
// ****************************************************************
`define SCG_PCLK_HALF      8'h04
`define SCG_HALF_W         8

`endif

// ---- rtl/scg_clk_gate.v ----
`timescale 1ns/1ps
`include "scg_regs.vh"

module scg_clk_gate (
    input  wire ref_clk_i,
    input  wire nrst_i,
    input  wire pclk_q_i,
    input  wire pclk_d_i,
    input  wire en_req_i,
    output wire clk_o,
    output wire en_o
);

    reg  en_q;
    reg  out_q;
    wire en_d;

    // Enable may only change while the primary phase is low
    assign en_d = pclk_q_i ? en_q : en_req_i;

    // Output follows primary phase, gated by the safe enable
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_q  <= 1'b0;
            out_q <= 1'b0;
        end else begin
            en_q  <= en_d;
            out_q <= pclk_d_i & en_d;
        end
    end

    assign clk_o = out_q;
    assign en_o  = en_q;

endmodule

// ---- rtl/scg_top.v ----
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "scg_regs.vh"
// Functional notes
// - Upstream timing comes from primary clock
// - Downstream timing comes from secondary clock input
// - Five outputs phase-locked to primary clock
// - Disable bit stops its clock output
// - Strap high, D2/D3hot: outputs held low
// - Strap low: power state leaves clocks

module scg_top #(
    parameter NUM_OUT = `SCG_NUM_OUT,
    parameter HALF_W  = `SCG_HALF_W,
    parameter [`SCG_HALF_W-1:0] PCLK_HALF = `SCG_PCLK_HALF
) (
    input  wire                   ref_clk_i,
    input  wire                   nrst_i,
    input  wire [`SCG_ADDR_W-1:0] addr_i,
    input  wire [31:0]            wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output wire [31:0]            rdata_o,
    input  wire                   secondary_clock_in_i,
    input  wire                   power_clock_gate_strap_i,
    output wire [NUM_OUT-1:0]     secondary_clock_outputs_o,
    output wire                   primary_clock_o,
    output wire                   primary_tick_o,
    output wire                   secondary_tick_o,
    output wire                   b2_state_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [HALF_W-1:0]            cnt_q;
    reg  [HALF_W-1:0]            cnt_d;
    reg                          pclk_q;
    reg                          pclk_d;
    reg                          ptick_q;
    reg                          sin_q;
    reg                          stick_q;
    reg  [NUM_OUT-1:0]           clkdis_q;
    reg  [`SCG_PSTATE_W-1:0]     pstate_q;
    reg                          strap_q;
    reg                          strap_done_q;
    reg  [31:0]                  rdata_q;
    reg  [31:0]                  rdata_d;
    wire                         low_power;
    wire                         b2;
    wire [NUM_OUT-1:0]           en_req;
    wire [NUM_OUT-1:0]           en_now;
    wire [NUM_OUT-1:0]           clk_out;
    wire                         wr_clkdis;
    wire                         wr_pstate;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // True when the port address selects the given register offset
    function hit;
        input [`SCG_ADDR_W-1:0] addr;
        input [`SCG_ADDR_W-1:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // Write strobes for the two writable registers
    assign wr_clkdis = wr_i & hit(addr_i, `SCG_OFS_CLKDIS);
    assign wr_pstate = wr_i & hit(addr_i, `SCG_OFS_PWRSTATE);

    // ****************************************************************
    // Primary clock phase generator
    // ****************************************************************

    // Divider: toggles the primary phase every PCLK_HALF cycles
    always @* begin
        cnt_d  = cnt_q + {{(HALF_W-1){1'b0}}, 1'b1};
        pclk_d = pclk_q;
        if (cnt_q == PCLK_HALF - {{(HALF_W-1){1'b0}}, 1'b1}) begin
            cnt_d  = {HALF_W{1'b0}};
            pclk_d = ~pclk_q;
        end
    end

    // Phase register and rising-edge enable for upstream logic
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q   <= {HALF_W{1'b0}};
            pclk_q  <= 1'b0;
            ptick_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            pclk_q  <= pclk_d;
            ptick_q <= pclk_d & ~pclk_q;
        end
    end

    // ****************************************************************
    // Secondary clock input edge detect
    // ****************************************************************

    // Downstream enable is taken from the fed-back input, not the divider
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sin_q   <= 1'b0;
            stick_q <= 1'b0;
        end else begin
            sin_q   <= secondary_clock_in_i;
            stick_q <= secondary_clock_in_i & ~sin_q;
        end
    end

    // ****************************************************************
    // Strap capture
    // ****************************************************************

    // Strap sampled once on the first edge after reset release
    // A static board pin, so no synchroniser and no later re-capture
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_q      <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_q      <= power_clock_gate_strap_i;
            strap_done_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Power management gating
    // ****************************************************************

    // Deep states are D2 and D3hot
    assign low_power = (pstate_q == `SCG_PSTATE_D2) || (pstate_q == `SCG_PSTATE_D3HOT);
    // Strap low keeps clocks running in any state
    assign b2        = strap_q & low_power;
    // Per-output enable request
    assign en_req    = ~clkdis_q & ~{NUM_OUT{b2}};

    // ****************************************************************
    // Output gates
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_gate
            scg_clk_gate u_gate (
                .ref_clk_i (ref_clk_i),
                .nrst_i    (nrst_i),
                .pclk_q_i  (pclk_q),
                .pclk_d_i  (pclk_d),
                .en_req_i  (en_req[gi]),
                .clk_o     (clk_out[gi]),
                .en_o      (en_now[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Register port
    // ****************************************************************

    // Configuration writes
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clkdis_q <= `SCG_CLKDIS_RST;
            pstate_q <= `SCG_PSTATE_RST;
        end else begin
            if (wr_clkdis) begin
                clkdis_q <= wdata_i[NUM_OUT-1:0];
            end
            if (wr_pstate) begin
                pstate_q <= wdata_i[`SCG_PSTATE_W-1:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (addr_i)
            `SCG_OFS_CLKDIS: begin
                rdata_d[NUM_OUT-1:0] = clkdis_q;
            end
            `SCG_OFS_PWRSTATE: begin
                rdata_d[`SCG_PSTATE_W-1:0] = pstate_q;
            end
            `SCG_OFS_STATUS: begin
                rdata_d[`SCG_STS_RUN_LSB+NUM_OUT-1:`SCG_STS_RUN_LSB] = en_now;
                rdata_d[`SCG_STS_B2_BIT]    = b2;
                rdata_d[`SCG_STS_STRAP_BIT] = strap_q;
                rdata_d[`SCG_STS_PCLK_BIT]  = pclk_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata_o                   = rdata_q;
    assign secondary_clock_outputs_o = clk_out;
    assign primary_clock_o           = pclk_q;
    assign primary_tick_o            = ptick_q;
    assign secondary_tick_o          = stick_q;
    assign b2_state_o                = b2;

endmodule

// ---- dv/scg_assertions.sv ----
`timescale 1ns/1ps
`include "scg_regs.vh"
// ****
// Gating checker
// ****
module scg_chk #(
    parameter [`SCG_HALF_W-1:0] PCLK_HALF = `SCG_PCLK_HALF
) (
    input wire       ref_clk_i,
    input wire       nrst_i,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire       wr_i,
    input wire       secondary_clock_in_i,
    input wire       power_clock_gate_strap_i,
    input wire [4:0] secondary_clock_outputs_o,
    input wire       primary_clock_o,
    input wire       primary_tick_o,
    input wire       secondary_tick_o,
    input wire       b2_state_o
);
    localparam int PER = 2 * PCLK_HALF;
    logic [4:0] dis_q;
    logic [1:0] pst_q;
    logic [2:0] qc_q;
    // Mirror gate controls; count quiet cycles since a write
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dis_q <= 5'h00;
            pst_q <= 2'h0;
            qc_q <= 3'h0;
        end else begin
            if (wr_i && addr_i == `SCG_OFS_CLKDIS) dis_q <= wdata_i[4:0];
            if (wr_i && addr_i == `SCG_OFS_PWRSTATE) pst_q <= wdata_i[1:0];
            qc_q <= wr_i ? 3'h0 : qc_q + {2'h0, qc_q != 3'h7};
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_out_phase: assert property (!primary_clock_o |-> secondary_clock_outputs_o == 5'h00)
        else $error("output high in low phase");
    a_pulse_whole: assert property (primary_clock_o && $past(primary_clock_o)
        |-> $stable(secondary_clock_outputs_o)) else $error("output changed in high phase");
    a_prim_period: assert property ($rose(primary_clock_o)
        |-> ##PER $rose(primary_clock_o)) else $error("primary period wrong");
    a_prim_tick: assert property (primary_tick_o == $rose(primary_clock_o))
        else $error("primary tick misplaced");
    a_sec_tick: assert property ($rose(secondary_clock_in_i) |=> secondary_tick_o)
        else $error("secondary tick missing");
    a_gate_match: assert property ($rose(primary_clock_o) && qc_q == 3'h7
        |-> secondary_clock_outputs_o == (~dis_q & {5{!b2_state_o}}))
        else $error("gated outputs wrong");
    a_b2_level: assert property (b2_state_o == (power_clock_gate_strap_i && pst_q[1]))
        else $error("b2 state wrong");
    a_b2_hold: assert property (b2_state_o [*8] |-> secondary_clock_outputs_o == 5'h00)
        else $error("outputs run in b2");
endmodule

bind scg_top scg_chk #(.PCLK_HALF(PCLK_HALF)) scg_chk_i (.ref_clk_i, .nrst_i, .addr_i,
    .wdata_i, .wr_i, .secondary_clock_in_i, .power_clock_gate_strap_i,
    .secondary_clock_outputs_o, .primary_clock_o, .primary_tick_o, .secondary_tick_o,
    .b2_state_o);

// ---- dv/scg_board_fb.sv ----
`timescale 1ns/1ps
// ****
// Board feedback path
// ****
module scg_board_fb (
    input  wire [4:0] clk_out_i,
    input  wire [2:0] sel_i,
    input  wire       async_i,
    input  wire       ext_clk_i,
    output wire       clk_in_o
);
    // Synchronous mode wires the selected output back; a stopped output stands low
    // Asynchronous mode leaves the outputs unused and feeds a shared external clock
    assign clk_in_o = async_i ? ext_clk_i : clk_out_i[sel_i];
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`include "scg_regs.vh"
// ****
// Bench
// ****
module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        strap = 1'b1;
    logic [2:0]  sel = 3'h1;
    logic        async_mode = 1'b0;
    logic        ext_clk = 1'b0;
    wire  [31:0] rdata_o;
    wire  [4:0]  outs;
    wire         sck, pclk, ptick, stick, b2;
    int          err_count = 0;
    int          cmp_count = 0;
    // Clock
    initial forever #2 ref_clk_i = ~ref_clk_i;
    // Block and board feedback
    scg_top #(.PCLK_HALF(8'h02)) scg_top_i (.ref_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .secondary_clock_in_i(sck), .power_clock_gate_strap_i(strap),
        .secondary_clock_outputs_o(outs), .primary_clock_o(pclk), .primary_tick_o(ptick),
        .secondary_tick_o(stick), .b2_state_o(b2));
    scg_board_fb scg_board_fb_i (.clk_out_i(outs), .sel_i(sel), .async_i(async_mode),
        .ext_clk_i(ext_clk), .clk_in_o(sck));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        d = rdata_o;
    endtask
    // Gather pulsing outputs and feedback ticks
    task obs(output logic [4:0] acc, output int n);
        acc = 5'h00;
        n = 0;
        repeat (24) begin
            @(negedge ref_clk_i);
            acc = acc | outs;
            n += stick;
        end
    endtask
    task do_reset(input logic s);
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        strap <= s;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
    endtask
    // Reset values, unmapped read, status, one-cycle read data
    task t_regs;
        logic [31:0] d;
        rd(`SCG_OFS_CLKDIS, d);
        chk(d, 32'h0);
        rd(`SCG_OFS_PWRSTATE, d);
        chk(d, 32'h0);
        rd(4'hc, d);
        chk(d, 32'h0);
        rd(`SCG_OFS_STATUS, d);
        chk(d & 32'h7f, {25'h0, strap, 1'b0, 5'h1f});
        @(negedge ref_clk_i);
        chk(rdata_o, 32'h0);
    endtask
    // Disable bits and feedback from a running and a stopped output
    task t_gate;
        logic [4:0] acc;
        int n;
        sel <= 3'h1;
        wr(`SCG_OFS_CLKDIS, 32'h15);
        repeat (8) @(posedge ref_clk_i);
        obs(acc, n);
        chk(acc, 5'h0a);
        chk(n, 6);
        @(posedge ref_clk_i);
        sel <= 3'h0;
        @(posedge ref_clk_i);
        obs(acc, n);
        chk(n, 0);
        wr(`SCG_OFS_CLKDIS, 32'h0);
    endtask
    // Every power state against the captured strap
    task t_power;
        logic [4:0] acc;
        int n;
        for (int p = 0; p < 4; p++) begin
            wr(`SCG_OFS_PWRSTATE, p);
            repeat (8) @(posedge ref_clk_i);
            obs(acc, n);
            chk(acc, (strap && p >= 2) ? 5'h00 : 5'h1f);
            chk(b2, strap && p >= 2);
        end
        wr(`SCG_OFS_PWRSTATE, 32'h0);
    endtask
    // Primary phase, its tick and the phase-locked outputs over six periods
    task t_prim;
        int np;
        int nh;
        np = 0;
        nh = 0;
        repeat (24) begin
            @(negedge ref_clk_i);
            np += ptick;
            nh += pclk;
            chk(outs, {5{pclk}});
        end
        chk(np, 6);
        chk(nh, 12);
    endtask
    // Asynchronous mode: outputs unused, secondary ticks follow an external clock
    task t_async;
        logic [4:0] acc;
        int n;
        @(posedge ref_clk_i);
        async_mode <= 1'b1;
        wr(`SCG_OFS_CLKDIS, 32'h1f);
        repeat (8) @(posedge ref_clk_i);
        acc = 5'h00;
        n = 0;
        for (int i = 0; i < 30; i++) begin
            @(posedge ref_clk_i);
            if (i % 3 == 0) ext_clk <= ~ext_clk;
            @(negedge ref_clk_i);
            acc = acc | outs;
            n += stick;
        end
        chk(acc, 5'h00);
        chk(n, 5);
        @(posedge ref_clk_i);
        async_mode <= 1'b0;
        wr(`SCG_OFS_CLKDIS, 32'h0);
        repeat (8) @(posedge ref_clk_i);
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        do_reset(1'b1);
        t_regs;
        t_prim;
        t_gate;
        t_async;
        t_power;
        do_reset(1'b0);
        t_regs;
        t_power;
        test_done;
    end
endmodule
